// File: rsc_map.svh
// register address, bit positions, reset values and timing figures of the reset-cause block
// assumes an 8-bit special-function register space and a 100 MHz block clock
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

`define RSC_SFR_ADDR 8'hef
`define RSC_BIT_MEM_ERR 6
`define RSC_BIT_COMP 5
`define RSC_BIT_SW 4
`define RSC_BIT_WDT 3
`define RSC_BIT_MCD 2
`define RSC_BIT_POR 1
`define RSC_BIT_PIN 0
`define RSC_REG_W 8
`define RSC_RDATA_IDLE 8'h00
`define RSC_SYNC_RESET 4'hf
`define RSC_VDD_EN_RESET 1'b1
`define RSC_CLK_PERIOD_NS 10
`define RSC_MCD_TIMEOUT_US 100
`define RSC_NS_PER_US 1000
`define RSC_MCD_TIMEOUT_CYC (`RSC_MCD_TIMEOUT_US * `RSC_NS_PER_US / `RSC_CLK_PERIOD_NS)
`define RSC_HOLD_CYC 16

`endif

// File: rsc_pkg.sv
// types shared by the reset-cause block
// assumes rsc_map.svh holds the numeric constants
package rsc_pkg;

	typedef enum logic [0:0] {
		RSC_RUN = 1'b0,
		RSC_HOLD = 1'b1
	} rsc_state_e;

	// one flag per reset cause, in register order from bit 6 down to bit 0
	typedef struct packed {
		logic mem_err;
		logic comp;
		logic sw;
		logic wdt;
		logic missing_clock_detector;
		logic por;
		logic pin;
	} rsc_cause_s;

	// level inputs that come from outside the clock domain
	typedef struct packed {
		logic pin_rst_b;
		logic comp_out;
		logic vdd_ok;
		logic clk_mon;
	} rsc_async_s;

endpackage

// File: rsc_clock_watch.sv
// missing-clock detector: times out when the watched clock level stands still too long
// assumes the watched level is already synchronised to ref_clk_in
`timescale 1ns/1ns
module rsc_clock_watch #(
	parameter int TIMEOUT_CYC = 10000
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// control and watched level
	input wire logic enable_in,
	input wire logic level_in,
	// result
	output logic timeout_out
);
	localparam int CW = $clog2(TIMEOUT_CYC + 1);

	generate
		if (TIMEOUT_CYC < 1) begin : g_bad
			$error("rsc_clock_watch: TIMEOUT_CYC must be at least 1");
		end
	endgenerate

	logic level_q;
	logic [CW-1:0] cnt_q;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			level_q <= 1'b0;
		end else begin
			level_q <= level_in;
		end
	end

	// a level change restarts the one-shot; the count saturates so the timeout stays up
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q <= '0;
		end else if (!enable_in || level_in != level_q) begin
			cnt_q <= '0;
		end else if (cnt_q != CW'(TIMEOUT_CYC)) begin
			cnt_q <= cnt_q + CW'(1); // see (R13)
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			timeout_out <= 1'b0;
		end else begin
			timeout_out <= enable_in && level_in == level_q && cnt_q == CW'(TIMEOUT_CYC); // see (R7)
		end
	end
endmodule

// File: rsc_reset_cause.sv
// reset-cause capture and reset-source enables, one special-function register
// assumes a core register port on the block clock; rst_b_in is the power-on reset
//
// Contract
// (R1) bit 6 is a read-only flag that is 1 when a code-memory access error caused the last reset.
// (R2) writing 1 to bit 5 enables a low comparator output as a reset source.
// (R3) reading bit 5 gives 1 when the comparator caused the last reset.
// (R4) writing 1 to bit 4 forces a full system reset at once.
// (R5) reading bit 4 gives 1 when the last reset was forced by software.
// (R6) bit 3 is a read-only flag that is 1 when a watchdog overflow caused the last reset.
// (R7) writing 1 to bit 2 enables the missing-clock detector, which then resets the system.
// (R8) reading bit 2 gives 1 when a missing-clock timeout caused the last reset.
// (R9) writing 1 to bit 1 selects the supply monitor as a reset source.
// (R10) software lets the supply monitor settle before selecting it, or a reset may follow.
// (R11) bit 1 reads 1 after any power-on or supply-monitor reset, other flags then undefined.
// (R12) bit 0 is a read-only flag that is 1 when the external reset pin caused the last reset.
// (R13) the missing-clock detector times out when the clock stands high or low over 100 us.
// (R14) with the comparator source enabled, reset is held while the comparator output is low.
// (R15) each reset clears every cause flag but the responsible one; bit 7 reads 0.
`timescale 1ns/1ns
`include "rsc_map.svh"
module rsc_reset_cause #(
	parameter int MCD_TIMEOUT_CYC = `RSC_MCD_TIMEOUT_CYC,
	parameter int HOLD_CYC = `RSC_HOLD_CYC
) (
	// clock and power-on reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// special-function register port
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	// reset sources from pins and analog detectors
	input wire rsc_pkg::rsc_async_s async_in,
	// reset sources from same-clock logic
	input wire logic wdt_overflow_in,
	input wire logic code_mem_error_in,
	// system reset and source enables
	output logic sys_rst_b_out,
	output logic comp_reset_en_out,
	output logic mcd_en_out,
	output logic vdd_reset_en_out
);
	import rsc_pkg::*;

	localparam int HW = $clog2(HOLD_CYC + 1);

	generate
		if (HOLD_CYC < 1) begin : g_bad_hold
			$error("rsc_reset_cause: HOLD_CYC must be at least 1");
		end
		if (MCD_TIMEOUT_CYC < 1) begin : g_bad_mcd
			$error("rsc_reset_cause: MCD_TIMEOUT_CYC must be at least 1");
		end
	endgenerate

	rsc_async_s sync1_q;
	rsc_async_s sync2_q;
	rsc_state_e state_q;
	rsc_state_e state_d;
	logic [HW-1:0] cnt_q;
	rsc_cause_s cause_q;
	rsc_cause_s cause_d;
	logic mcd_timeout;
	logic mcd_req;
	logic hold_exit;
	logic sfr_hit_wr;
	logic pin_req;
	logic vdd_req;
	logic comp_req;
	logic sw_req;
	logic level_req;
	logic any_req;

	// two flops before any logic reads the asynchronous levels
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync1_q <= `RSC_SYNC_RESET;
			sync2_q <= `RSC_SYNC_RESET;
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	rsc_clock_watch #(
		.TIMEOUT_CYC(MCD_TIMEOUT_CYC)
	) u_clock_watch (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.enable_in(mcd_en_out),
		.level_in(sync2_q.clk_mon),
		.timeout_out(mcd_timeout)
	);

	assign sfr_hit_wr = sfr_wr_in && sfr_addr_in == `RSC_SFR_ADDR && state_q == RSC_RUN;
	assign pin_req = !sync2_q.pin_rst_b; // see (R12)
	assign vdd_req = vdd_reset_en_out && !sync2_q.vdd_ok; // see (R9)
	assign comp_req = comp_reset_en_out && !sync2_q.comp_out; // see (R2)
	assign sw_req = sfr_hit_wr && sfr_wdata_in[`RSC_BIT_SW]; // see (R4)
	// the watcher's registered timeout trails its enable by a cycle, so gate it here too
	assign mcd_req = mcd_en_out && mcd_timeout; // see (R7)
	assign level_req = pin_req || vdd_req || comp_req;
	assign any_req = level_req || mcd_req || wdt_overflow_in || code_mem_error_in || sw_req;
	assign hold_exit = state_q == RSC_HOLD && state_d == RSC_RUN;

	// only the highest-priority cause is kept; the supply monitor outranks everything
	always_comb begin
		cause_d = '0;
		if (vdd_req) begin
			cause_d.por = 1'b1; // see (R11)
		end else if (pin_req) begin
			cause_d.pin = 1'b1; // see (R12)
		end else if (mcd_req) begin
			cause_d.missing_clock_detector = 1'b1; // see (R8)
		end else if (comp_req) begin
			cause_d.comp = 1'b1; // see (R3)
		end else if (wdt_overflow_in) begin
			cause_d.wdt = 1'b1; // see (R6)
		end else if (code_mem_error_in) begin
			cause_d.mem_err = 1'b1; // see (R1)
		end else begin
			cause_d.sw = 1'b1; // see (R5)
		end
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			RSC_RUN: begin
				if (any_req) begin
					state_d = RSC_HOLD;
				end
			end
			RSC_HOLD: begin
				if (!level_req && cnt_q == HW'(HOLD_CYC - 1)) begin
					state_d = RSC_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= RSC_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	// a level source keeps restarting the hold count, so reset lasts as long as it does
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q <= '0;
		end else if (state_q == RSC_RUN || level_req) begin
			cnt_q <= '0; // see (R14)
		end else if (state_d == RSC_HOLD) begin
			cnt_q <= cnt_q + HW'(1);
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sys_rst_b_out <= 1'b0;
		end else begin
			sys_rst_b_out <= state_d == RSC_RUN; // see (R4)
		end
	end

	// power-on sets only the power flag; a supply drop during a hold takes over the cause
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cause_q <= '0;
			cause_q.por <= 1'b1; // see (R11)
		end else if (state_q == RSC_RUN && any_req) begin
			cause_q <= cause_d; // see (R15)
		end else if (state_q == RSC_HOLD && vdd_req) begin
			cause_q <= cause_d; // see (R11)
		end
	end

	// detector enables fall at the end of every reset; the supply monitor stays selected
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			comp_reset_en_out <= 1'b0;
		end else if (hold_exit) begin
			comp_reset_en_out <= 1'b0;
		end else if (sfr_hit_wr && !sw_req) begin
			comp_reset_en_out <= sfr_wdata_in[`RSC_BIT_COMP]; // see (R2)
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mcd_en_out <= 1'b0;
		end else if (hold_exit) begin
			mcd_en_out <= 1'b0;
		end else if (sfr_hit_wr && !sw_req) begin
			mcd_en_out <= sfr_wdata_in[`RSC_BIT_MCD]; // see (R7)
		end
	end

	// a write with the force bit set leaves every enable as it was
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			vdd_reset_en_out <= `RSC_VDD_EN_RESET;
		end else if (sfr_hit_wr && !sw_req) begin
			vdd_reset_en_out <= sfr_wdata_in[`RSC_BIT_POR]; // see (R9)
		end
	end

	// reads return the causes, bit 7 always zero; other addresses read as zero
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sfr_rdata_out <= `RSC_RDATA_IDLE;
		end else if (sfr_addr_in == `RSC_SFR_ADDR) begin
			sfr_rdata_out <= {1'b0, cause_q}; // see (R15)
		end else begin
			sfr_rdata_out <= `RSC_RDATA_IDLE;
		end
	end
endmodule

// File: rsc_reset_cause_chk.sv
// assertions on the reset-cause block ports
// assumes the bind hands on the block's own parameters
`timescale 1ns/1ns
module rsc_reset_cause_chk #(
	parameter int MCD_TIMEOUT_CYC = 20,
	parameter int HOLD_CYC = 4
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// register port
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	// reset sources
	input wire rsc_pkg::rsc_async_s async_in,
	input wire logic wdt_overflow_in,
	input wire logic code_mem_error_in,
	// results
	input wire logic sys_rst_b_out,
	input wire logic comp_reset_en_out,
	input wire logic mcd_en_out,
	input wire logic vdd_reset_en_out
);
	import rsc_pkg::*;
	int low_q;
	int still_q;
	logic mon_q;
	default clocking dc @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	// length of the current system reset
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			low_q <= 0;
		else
			low_q <= sys_rst_b_out ? 0 : low_q + 1;
	end
	// cycles the watched clock level has stood still
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			mon_q <= 1'b0;
		else
			mon_q <= async_in.clk_mon;
	end
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			still_q <= 0;
		else
			still_q <= (async_in.clk_mon != mon_q) ? 0 : still_q + 1;
	end
	sequence s_pulse;
		sys_rst_b_out && (wdt_overflow_in || code_mem_error_in);
	endsequence
	sequence s_run_wr;
		sys_rst_b_out && sfr_wr_in && sfr_addr_in == 8'hef;
	endsequence
	sequence s_cfg_wr;
		s_run_wr ##0 !sfr_wdata_in[4];
	endsequence
	a_pulse_trip: assert property (s_pulse |=> !sys_rst_b_out)
		else $error("pulse source gave no reset");
	a_sw_force: assert property (s_run_wr ##0 sfr_wdata_in[4] |=> !sys_rst_b_out)
		else $error("software force gave no reset");
	a_comp_enable: assert property (s_cfg_wr |=> comp_reset_en_out == $past(sfr_wdata_in[5]))
		else $error("comparator enable not taken");
	a_mcd_enable: assert property (s_cfg_wr |=> mcd_en_out == $past(sfr_wdata_in[2]))
		else $error("missing-clock enable not taken");
	a_vdd_select: assert property (s_cfg_wr |=> vdd_reset_en_out == $past(sfr_wdata_in[1]))
		else $error("supply monitor select not taken");
	a_comp_hold: assert property ((comp_reset_en_out && !async_in.comp_out) [*3]
		|-> ##[0:2] !sys_rst_b_out)
		else $error("low comparator did not hold reset");
	a_pin_hold: assert property ((!async_in.pin_rst_b) [*3] |-> ##[0:2] !sys_rst_b_out)
		else $error("low reset pin did not hold reset");
	a_mcd_late: assert property (mcd_en_out && still_q > MCD_TIMEOUT_CYC + 6 |-> !sys_rst_b_out)
		else $error("stopped clock gave no reset");
	a_hold_len: assert property ($rose(sys_rst_b_out) |-> low_q >= HOLD_CYC - 1)
		else $error("system reset too short");
	a_bit7_zero: assert property (sfr_rdata_out[7] == 1'b0)
		else $error("bit 7 read as one");
endmodule

bind rsc_reset_cause rsc_reset_cause_chk #(.MCD_TIMEOUT_CYC(MCD_TIMEOUT_CYC), .HOLD_CYC(HOLD_CYC)) chk (
	.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .sfr_addr_in(sfr_addr_in),
	.sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
	.async_in(async_in), .wdt_overflow_in(wdt_overflow_in),
	.code_mem_error_in(code_mem_error_in), .sys_rst_b_out(sys_rst_b_out),
	.comp_reset_en_out(comp_reset_en_out), .mcd_en_out(mcd_en_out),
	.vdd_reset_en_out(vdd_reset_en_out));

// File: rsc_tb.sv
// self-checking bench for the reset-cause block
// assumes short sim counts: timeout 20, hold 4
`timescale 1ns/1ns
module testbench;
	import rsc_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic wr = 1'b0;
	logic wdt = 1'b0;
	logic mem = 1'b0;
	logic freeze = 1'b0;
	logic rd_p = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] d;
	logic sys, comp_en, mcd_en, vdd_en;
	rsc_async_s av = 4'hf;
	logic [7:0] exp_q[$];
	logic [7:0] cause_t [7] = '{8'h01, 8'h20, 8'h04, 8'h08, 8'h40, 8'h10, 8'h02};
	int error_cnt = 0;
	int check_count = 0;
	int seed = 45838;
	rsc_reset_cause #(.MCD_TIMEOUT_CYC(20), .HOLD_CYC(4)) dut (
		.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
		.sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .async_in(av), .wdt_overflow_in(wdt),
		.code_mem_error_in(mem), .sys_rst_b_out(sys), .comp_reset_en_out(comp_en),
		.mcd_en_out(mcd_en), .vdd_reset_en_out(vdd_en));
	initial forever #5 ref_clk_in = ~ref_clk_in;
	// watched clock toggles unless a scenario stops it
	always @(posedge ref_clk_in) if (!freeze) av.clk_mon <= ~av.clk_mon;
	// read data lands at the edge after the address; looked at on the falling edge, settled
	always @(posedge ref_clk_in) rd_p <= (addr === 8'hef && wr === 1'b0);
	always @(negedge ref_clk_in) begin
		if (rd_p)
			chk("rdata", exp_q.pop_front(), rdata);
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(logic [7:0] e);
		exp_q.push_back(e);
		addr <= 8'hef;
		@(posedge ref_clk_in) addr <= 8'h00;
		@(posedge ref_clk_in);
	endtask
	task automatic wr_reg(logic [7:0] v);
		wr <= 1'b1;
		addr <= 8'hef;
		wdata <= v;
		@(posedge ref_clk_in) wr <= 1'b0;
		addr <= 8'h00;
	endtask
	task automatic wait_lvl(logic v);
		int n;
		n = 0;
		while (sys !== v && n < 300) begin
			@(posedge ref_clk_in);
			n++;
		end
		if (n >= 300) begin
			error_cnt++;
			test_done();
		end
	endtask
	task automatic test_done();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		wait_lvl(1'b1);
		rd(8'h02);
		repeat (4) begin
			d = 8'($random(seed)) & 8'hef;
			wr_reg(d);
			@(negedge ref_clk_in);
			chk("en", {5'h00, d[5], d[2], d[1]}, {5'h00, comp_en, mcd_en, vdd_en});
			@(posedge ref_clk_in);
		end
		// comparator low while not enabled must not reset
		wr_reg(8'h02);
		av.comp_out <= 1'b0;
		repeat (5) @(posedge ref_clk_in);
		chk("sys", 8'h01, {7'h00, sys});
		av.comp_out <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			case (i)
				0: av.pin_rst_b <= 1'b0;
				1: begin
					wr_reg(8'h20);
					av.comp_out <= 1'b0;
				end
				2: begin
					wr_reg(8'h04);
					freeze <= 1'b1;
				end
				3: wdt <= 1'b1;
				4: mem <= 1'b1;
				5: wr_reg(8'h10);
				default: begin
					wr_reg(8'h02);
					av.vdd_ok <= 1'b0;
				end
			endcase
			@(posedge ref_clk_in);
			wdt <= 1'b0;
			mem <= 1'b0;
			wait_lvl(1'b0);
			av.pin_rst_b <= 1'b1;
			av.comp_out <= 1'b1;
			av.vdd_ok <= 1'b1;
			freeze <= 1'b0;
			wait_lvl(1'b1);
			rd(cause_t[i]);
		end
		// enables from a write, then a second power-on in mid-run restores the reset values
		wr_reg(8'h24);
		@(negedge ref_clk_in);
		chk("en", 8'h06, {5'h00, comp_en, mcd_en, vdd_en});
		@(posedge ref_clk_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		wait_lvl(1'b1);
		chk("en", 8'h01, {5'h00, comp_en, mcd_en, vdd_en});
		rd(8'h02);
		test_done();
	end
endmodule
